//--- clkgen_cfg_pkg.sv
package clkgen_cfg_pkg;

	// ****************************************
	// Link addressing and command code layout
	// ****************************************
	localparam logic [6:0] DEV_ADDR = 7'h69;   // 8-bit form with write bit is 0xd2
	localparam int CMD_MODE_BIT = 7;            // 1 = single byte, 0 = block
	localparam int CMD_CS_HI = 6;
	localparam int CMD_CS_LO = 5;
	localparam logic [1:0] CMD_CS_VALUE = 2'h0;
	localparam logic [4:0] NUM_REGS = 5'h08;
	localparam logic [4:0] ID_REG = 5'h07;      // Read-only identity byte

	// ****************************************
	// Control register contents
	// ****************************************
	localparam logic [7:0] REG_DEFAULT [0:7] = '{8'h7c, 8'h00, 8'heb, 8'haf, 8'h01, 8'h00, 8'h13, 8'h00};
	localparam int OE_REG = 0;
	localparam int OE1_BIT = 3;
	localparam int OE2_BIT = 4;
	localparam int SPREAD_REG = 2;
	localparam int SPREAD_ON_BIT = 2;
	localparam int SPREAD_AMT_BIT = 7;
	localparam int TEST_REG = 6;
	localparam int TEST_MODE_BIT = 6;
	localparam int TEST_SEL_BIT = 7;

	// ****************************************
	// Host timing and register map
	// ****************************************
	localparam int CLK_HZ = 20000000;
	localparam int SCL_MAX_HZ = 400000;
	localparam int QUARTER_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
	localparam logic [4:0] QCNT_LAST = 5'(QUARTER_CYC - 1);
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] DATA0_OFS = 8'h08;
	localparam logic [7:0] DATA1_OFS = 8'h0c;
	localparam int CTRL_RD_BIT = 16;
	localparam int CTRL_GO_BIT = 17;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] LEN_RESET = 8'h00;

	// ****************************************
	// State encodings
	// ****************************************
	typedef enum logic [6:0] {
		PH_IDLE = 7'h01, PH_ADDR = 7'h02, PH_CMD = 7'h04, PH_COUNT = 7'h08,
		PH_WDATA = 7'h10, PH_RDATA = 7'h20, PH_IGNORE = 7'h40
	} dev_phase_t;

	typedef enum logic [9:0] {
		H_IDLE = 10'h001, H_START = 10'h002, H_ADDRW = 10'h004, H_CMD = 10'h008, H_COUNT = 10'h010,
		H_WDATA = 10'h020, H_RSTART = 10'h040, H_ADDRR = 10'h080, H_RDATA = 10'h100, H_STOP = 10'h200
	} host_state_t;

endpackage

//--- i2c_link_if.sv
`timescale 1ns/1ns
interface i2c_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-ups: any enabled driver pulls low
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o) ? 1'b0 : 1'b1;

	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

//--- clkgen_cfg_slave.sv
`timescale 1ns/1ns
module clkgen_cfg_slave import clkgen_cfg_pkg::*; #(
	parameter logic [7:0] ID_BYTE = 8'h00       // Identity byte, value arbitrary
) (
	input wire logic link_clk_i,                 // Device sampling clock
	input wire logic rst_i,                      // Synchronous reset, high
	i2c_link_if.dev link,                        // Serial link
	output logic [1:0] out_en_o,                 // Output buffer enables 2,1
	output logic spread_on_o,                    // Spread modulation on
	output logic spread_amount_select_o,         // 0 = -0.35%, 1 = -0.5%
	output logic [1:0] test_ctl_o                // Test select, test mode
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic scl_now;
	logic sda_now;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// Two flops then one history flop; stage 0 feeds stage 1 only.
	// Sampling at 30 ns leaves wide margin at a 2.5 us bit time.
	always_ff @(posedge link_clk_i) begin
		if (rst_i) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], link.scl};
			sda_sync <= {sda_sync[1:0], link.sda};
		end
	end

	assign scl_now = scl_sync[1];
	assign sda_now = sda_sync[1];
	assign scl_rise = scl_now & ~scl_sync[2];
	assign scl_fall = ~scl_now & scl_sync[2];
	// Start and stop are sda edges while scl stays high
	assign start_det = scl_now & scl_sync[2] & sda_sync[2] & ~sda_now;
	assign stop_det = scl_now & scl_sync[2] & ~sda_sync[2] & sda_now;

	// ****************************************
	// Protocol engine
	// ****************************************
	dev_phase_t phase;
	logic [3:0] bitcnt;
	logic [7:0] rx;
	logic [7:0] tx;
	logic [4:0] idx;
	logic byte_mode;
	logic ack_drv;
	logic tx_on;
	logic host_ack;
	logic first_tx;
	logic count_pending;
	logic byte_done;
	logic wr_strobe;
	logic [7:0] rd_byte;
	logic [7:0] regs [0:7];

	assign byte_done = scl_fall & (bitcnt == 4'h8);
	// Out-of-range bytes read as zero and absorb writes
	assign rd_byte = (idx < NUM_REGS) ? regs[idx[2:0]] : 8'h00;

	// Byte-level sequencing; a stop anywhere ends the transfer and
	// what was already written stays written
	always_ff @(posedge link_clk_i) begin
		if (rst_i || stop_det) begin
			phase <= PH_IDLE;
			bitcnt <= 4'h0;
			ack_drv <= 1'b0;
			tx_on <= 1'b0;
		end else if (start_det) begin
			phase <= PH_ADDR;
			bitcnt <= 4'h0;
			ack_drv <= 1'b0;
			tx_on <= 1'b0;
		end else if (phase != PH_IDLE) begin
			if (scl_rise) begin
				if (bitcnt < 4'h8) begin
					rx <= {rx[6:0], sda_now};
				end else begin
					host_ack <= ~sda_now;
				end
				if (bitcnt != 4'h9) begin
					bitcnt <= bitcnt + 4'h1;
				end
			end
			if (byte_done) begin
				case (phase)
					PH_ADDR: begin
						if (rx[7:1] != DEV_ADDR) begin
							phase <= PH_IGNORE;
						end else if (rx[0]) begin
							phase <= PH_RDATA;
							ack_drv <= 1'b1;
							first_tx <= 1'b1;
							count_pending <= ~byte_mode;
						end else begin
							phase <= PH_CMD;
							ack_drv <= 1'b1;
						end
					end
					PH_CMD: begin
						if (rx[CMD_CS_HI:CMD_CS_LO] != CMD_CS_VALUE) begin
							phase <= PH_IGNORE;
						end else begin
							ack_drv <= 1'b1;
							byte_mode <= rx[CMD_MODE_BIT];
							idx <= rx[CMD_MODE_BIT] ? rx[4:0] : 5'h00;
							phase <= rx[CMD_MODE_BIT] ? PH_WDATA : PH_COUNT;
						end
					end
					PH_COUNT: begin
						ack_drv <= 1'b1;
						phase <= PH_WDATA;
					end
					PH_WDATA: begin
						ack_drv <= 1'b1;
						idx <= idx + 5'h01;
					end
					// Let go of the last data bit on the clock fall, never while scl is high,
					// or the release would look like a stop
					PH_RDATA: begin
						ack_drv <= 1'b0;
						tx_on <= 1'b0;
					end
					default: begin
						ack_drv <= 1'b0;
					end
				endcase
			end else if (scl_fall && bitcnt == 4'h9) begin
				bitcnt <= 4'h0;
				ack_drv <= 1'b0;
				// Keep sending only after an ack; a nack ends the read
				if (phase == PH_RDATA && (first_tx || host_ack)) begin
					tx_on <= 1'b1;
					first_tx <= 1'b0;
					if (count_pending) begin
						tx <= {3'h0, NUM_REGS};
						count_pending <= 1'b0;
					end else begin
						tx <= rd_byte;
						idx <= idx + 5'h01;
					end
				end else begin
					tx_on <= 1'b0;
					if (phase == PH_RDATA) begin
						phase <= PH_IGNORE;
					end
				end
			end else if (scl_fall && tx_on) begin
				tx <= {tx[6:0], 1'b0};
			end
		end
	end

	// Open drain: only ever pull low, released bits float high
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = ack_drv | (tx_on & ~tx[7]);

	// ****************************************
	// Control registers
	// ****************************************
	assign wr_strobe = byte_done & (phase == PH_WDATA) & (idx < ID_REG);

	// Each byte reloads its default on reset; the identity byte never changes
	generate
		for (genvar g = 0; g < 8; g++) begin : g_reg
			always_ff @(posedge link_clk_i) begin
				if (rst_i) begin
					regs[g] <= (g == ID_REG) ? ID_BYTE : REG_DEFAULT[g];
				end else if (wr_strobe && idx[2:0] == 3'(g)) begin
					regs[g] <= rx;
				end
			end
		end
	endgenerate

	// Control bits steer the clock outputs straight from the flops
	assign out_en_o = {regs[OE_REG][OE2_BIT], regs[OE_REG][OE1_BIT]};
	assign spread_on_o = regs[SPREAD_REG][SPREAD_ON_BIT];
	assign spread_amount_select_o = regs[SPREAD_REG][SPREAD_AMT_BIT];
	assign test_ctl_o = {regs[TEST_REG][TEST_SEL_BIT], regs[TEST_REG][TEST_MODE_BIT]};

endmodule

//--- cfg_host_ctrl.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module cfg_host_ctrl import clkgen_cfg_pkg::*; (
	input wire logic clk_i,            // System clock, 20 MHz
	input wire logic rst_i,            // Synchronous reset, high
	input wire logic psel_i,           // APB select
	input wire logic penable_i,        // APB enable
	input wire logic pwrite_i,         // APB write
	input wire logic [7:0] paddr_i,    // APB byte address
	input wire logic [31:0] pwdata_i,  // APB write data
	output logic [31:0] prdata_o,      // APB read data
	output logic pready_o,             // APB ready
	output logic pslverr_o,            // APB error, unmapped address
	i2c_link_if.host link              // Serial link
);

	// ****************************************
	// Registers and APB slave
	// ****************************************
	host_state_t state;
	logic [7:0] cmd_code;
	logic [7:0] len;
	logic rd_dir;
	logic nack_flag;
	logic [7:0] buf_mem [0:7];
	logic [3:0] bi;
	logic [7:0] rx;
	logic go;
	logic mapped;
	logic blk;

	assign mapped = paddr_i == CTRL_OFS || paddr_i == STAT_OFS || paddr_i == DATA0_OFS || paddr_i == DATA1_OFS;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign go = psel_i & penable_i & pwrite_i & (paddr_i == CTRL_OFS) & pwdata_i[CTRL_GO_BIT] & (state == H_IDLE);
	assign blk = ~cmd_code[CMD_MODE_BIT];

	// Command fields are frozen while a transfer runs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_code <= CMD_RESET;
			len <= LEN_RESET;
			rd_dir <= 1'b0;
		end else if (psel_i && penable_i && pwrite_i && paddr_i == CTRL_OFS && state == H_IDLE) begin
			cmd_code <= pwdata_i[7:0];
			len <= pwdata_i[15:8];
			rd_dir <= pwdata_i[CTRL_RD_BIT];
		end
	end

	// Read data is latched in the setup cycle so it is a flop in the access cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_o <= 32'h0;
		end else if (psel_i && !penable_i) begin
			case (paddr_i)
				CTRL_OFS: prdata_o <= {15'h0, rd_dir, len, cmd_code};
				STAT_OFS: prdata_o <= {24'h0, bi, 2'h0, nack_flag, state != H_IDLE};
				DATA0_OFS: prdata_o <= {buf_mem[3], buf_mem[2], buf_mem[1], buf_mem[0]};
				DATA1_OFS: prdata_o <= {buf_mem[7], buf_mem[6], buf_mem[5], buf_mem[4]};
				default: prdata_o <= 32'h0;
			endcase
		end
	end

	// ****************************************
	// Bit timing: four quarters per serial bit
	// ****************************************
	logic [4:0] qcnt;
	logic [1:0] q;
	logic [3:0] bitn;
	logic tick;
	logic is_byte;
	logic atom_end;
	logic last_rd;
	logic [1:0] sda_sync;
	logic [7:0] tx_byte;
	logic next_scl_low;
	logic next_sda_low;
	logic scl_low;
	logic sda_low;

	assign tick = qcnt == QCNT_LAST;   // Quarter rounded up keeps scl at or below 400 kHz
	assign is_byte = state inside {H_ADDRW, H_CMD, H_COUNT, H_WDATA, H_ADDRR, H_RDATA};
	assign atom_end = tick & (q == 2'h3) & (!is_byte || bitn == 4'h8);
	assign last_rd = bi == (blk ? len[3:0] : 4'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i || state == H_IDLE) begin
			qcnt <= 5'h00;
		end else begin
			qcnt <= tick ? 5'h00 : qcnt + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_sync <= 2'h3;
		end else begin
			sda_sync <= {sda_sync[0], link.sda};
		end
	end

	// Byte placed on the wire in each phase, MSB first
	always_comb begin
		case (state)
			H_ADDRW: tx_byte = {DEV_ADDR, 1'b0};
			H_CMD: tx_byte = cmd_code;
			H_COUNT: tx_byte = len;
			H_WDATA: tx_byte = buf_mem[bi[2:0]];
			H_ADDRR: tx_byte = {DEV_ADDR, 1'b1};
			default: tx_byte = 8'hff;
		endcase
	end

	// Wire levels per quarter; sda only moves while scl is low except at start and stop
	always_comb begin
		// No low pulse in the first start quarter: a stray clock on an idle bus would cut the low time
		next_scl_low = (state != H_IDLE) && ((q == 2'h0 && state != H_START) || (q == 2'h3 && state != H_STOP));
		case (state)
			H_START, H_RSTART: next_sda_low = q[1];
			H_STOP: next_sda_low = ~q[1];
			H_RDATA: next_sda_low = (bitn == 4'h8) && !last_rd;
			H_IDLE: next_sda_low = 1'b0;
			default: next_sda_low = (bitn < 4'h8) && !tx_byte[3'h7 - bitn[2:0]];
		endcase
	end

	// Registered pin drive avoids glitches on the open-drain wires
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_low <= 1'b0;
			sda_low <= 1'b0;
		end else begin
			scl_low <= next_scl_low;
			sda_low <= next_sda_low;
		end
	end

	assign link.host_scl_o = 1'b0;
	assign link.host_scl_oe = scl_low;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = sda_low;

	// ****************************************
	// Transfer sequencer
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= H_IDLE;
			q <= 2'h0;
			bitn <= 4'h0;
			bi <= 4'h0;
			nack_flag <= 1'b0;
		end else if (state == H_IDLE) begin
			if (go) begin
				state <= H_START;
				q <= 2'h0;
				bitn <= 4'h0;
				bi <= 4'h0;
				nack_flag <= 1'b0;
			end
		end else if (tick) begin
			q <= q + 2'h1;
			if (q == 2'h2 && bitn < 4'h8) begin
				rx <= {rx[6:0], sda_sync[1]};
			end
			if (q == 2'h2 && bitn == 4'h8 && state != H_RDATA) begin
				nack_flag <= sda_sync[1];
			end
			if (q == 2'h3 && is_byte) begin
				bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
			end
			if (atom_end) begin
				case (state)
					H_START: state <= H_ADDRW;
					H_ADDRW: state <= nack_flag ? H_STOP : H_CMD;
					H_CMD: state <= nack_flag ? H_STOP : rd_dir ? H_RSTART : blk ? H_COUNT : H_WDATA;
					H_COUNT: state <= (nack_flag || len == 8'h00) ? H_STOP : H_WDATA;
					H_WDATA: begin
						bi <= bi + 4'h1;
						if (nack_flag || bi == (blk ? len[3:0] - 4'h1 : 4'h0)) begin
							state <= H_STOP;
						end
					end
					H_RSTART: state <= H_ADDRR;
					H_ADDRR: state <= nack_flag ? H_STOP : H_RDATA;
					H_RDATA: begin
						bi <= bi + 4'h1;
						if (last_rd) begin
							state <= H_STOP;
						end
					end
					default: state <= H_IDLE;
				endcase
			end
		end
	end

	// Buffer bytes: written by software, or filled by reads in arrival order
	always_ff @(posedge clk_i) begin
		if (psel_i && penable_i && pwrite_i && state == H_IDLE && paddr_i == DATA0_OFS) begin
			for (int i = 0; i < 4; i++) begin
				buf_mem[i] <= pwdata_i[8 * i +: 8];
			end
		end else if (psel_i && penable_i && pwrite_i && state == H_IDLE && paddr_i == DATA1_OFS) begin
			for (int i = 0; i < 4; i++) begin
				buf_mem[i + 4] <= pwdata_i[8 * i +: 8];
			end
		end else if (state == H_RDATA && atom_end) begin
			buf_mem[bi[2:0]] <= rx;
		end
	end

endmodule

//--- clkgen_cfg_asserts.sv
`timescale 1ns/1ns
module clkgen_cfg_asserts import clkgen_cfg_pkg::*; (
	input wire logic clk_i, // Host clock
	input wire logic link_clk_i, // Device clock
	input wire logic rst_i, // Reset, high
	input wire logic dev_sda_oe, // Device pulls sda
	input wire logic scl, // Resolved clock line
	input wire logic sda // Resolved data line
);
	// ****************
	// Bus decoding
	// ****************
	logic scl_q, sda_q, hscl_q;
	logic [3:0] bit_cnt;
	logic [2:0] byte_no;
	logic [7:0] sh, addr_b, cmd_b;
	logic [6:0] lvl_cnt;
	wire nine = scl & ~scl_q & (bit_cnt == 4'h8);

	// Line history and byte capture; no reset needed, a start realigns them
	always_ff @(posedge link_clk_i) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl & ~scl_q & (bit_cnt != 4'h8))
			sh <= {sh[6:0], sda};
		if (nine & (byte_no == 3'h0))
			addr_b <= sh;
		// Command byte of a write frame tells block reads from byte reads
		if (nine & (byte_no == 3'h1) & ~addr_b[0])
			cmd_b <= sh;
	end

	// Bit and byte position since the last start
	always_ff @(posedge link_clk_i) begin
		if (rst_i | (scl & scl_q & sda_q & ~sda)) begin
			bit_cnt <= 4'h0;
			byte_no <= 3'h0;
		end else if (scl & ~scl_q) begin
			bit_cnt <= nine ? 4'h0 : bit_cnt + 4'h1;
			if (nine & (byte_no != 3'h7))
				byte_no <= byte_no + 3'h1;
		end
	end

	// Length of the current scl level in host clocks, saturating
	always_ff @(posedge clk_i) begin
		hscl_q <= scl;
		if (rst_i)
			lvl_cnt <= 7'h0;
		else if (scl != hscl_q)
			lvl_cnt <= 7'h1;
		else if (lvl_cnt != 7'h7f)
			lvl_cnt <= lvl_cnt + 7'h1;
	end

	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence

	// ****************
	// Checks
	// ****************
	chk_dev_reset_idle: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !dev_sda_oe) else $error("device drives sda after reset");
	chk_bus_idle_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> scl && sda) else $error("bus not idle after reset");
	chk_sda_turn_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$changed(dev_sda_oe) |-> !scl && !$past(scl)) else $error("device sda changed with scl high");
	chk_start_quiet: assert property (@(posedge link_clk_i) disable iff (rst_i)
		s_start |=> !dev_sda_oe [*8]) else $error("device drives sda just after start");
	chk_addr_ack: assert property (@(posedge link_clk_i) disable iff (rst_i)
		nine && byte_no == 3'h0 && sh[7:1] == DEV_ADDR |-> !sda) else $error("own address not acked");
	chk_cmd_cs_ack: assert property (@(posedge link_clk_i) disable iff (rst_i)
		nine && byte_no == 3'h1 && addr_b == {DEV_ADDR, 1'b0} |-> sda == (sh[CMD_CS_HI:CMD_CS_LO] != CMD_CS_VALUE))
		else $error("command ack wrong for chip select");
	chk_count_byte: assert property (@(posedge link_clk_i) disable iff (rst_i)
		nine && byte_no == 3'h1 && addr_b == {DEV_ADDR, 1'b1} && !cmd_b[CMD_MODE_BIT] |-> sh == 8'h08)
		else $error("bad count byte");
	chk_scl_low_min: assert property (@(posedge clk_i) disable iff (rst_i)
		scl && !hscl_q |-> lvl_cnt >= 7'h1a) else $error("scl low too short");
	chk_scl_high_min: assert property (@(posedge clk_i) disable iff (rst_i)
		!scl && hscl_q |-> lvl_cnt >= 7'h0c) else $error("scl high too short");
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top import clkgen_cfg_pkg::*; ();
	logic clk_i = 1'b0, link_clk = 1'b0, rst_i = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, st;
	logic pready, pslverr, err, ack_n, spread_on, amt;
	logic [1:0] out_en, test_ctl, out_en2;
	logic [23:0] tbl [0:5] = '{24'h02040e, 24'h02800d, 24'h000805, 24'h001009, 24'h06c039, 24'h075539};
	logic [15:0] rb [0:3] = '{16'h0010, 16'h0280, 16'h06c0, 16'h0700};
	int errors = 0, checks_done = 0, cycles = 0;

	i2c_link_if lk();
	i2c_link_if lk2();
	cfg_host_ctrl cfg_host_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .link(lk.host));
	clkgen_cfg_slave clkgen_cfg_slave_i (.link_clk_i(link_clk), .rst_i(rst_i), .link(lk.dev), .out_en_o(out_en),
		.spread_on_o(spread_on), .spread_amount_select_o(amt), .test_ctl_o(test_ctl));
	// Second device, driven by hand to send a foreign address as well as its own
	clkgen_cfg_slave spare_slave_i (.link_clk_i(link_clk), .rst_i(rst_i), .link(lk2.dev), .out_en_o(out_en2),
		.spread_on_o(), .spread_amount_select_o(), .test_ctl_o());
	clkgen_cfg_asserts clkgen_cfg_asserts_i (.clk_i(clk_i), .link_clk_i(link_clk), .rst_i(rst_i),
		.dev_sda_oe(lk.dev_sda_oe), .scl(lk.scl), .sda(lk.sda));

	// Link clock offset by 7 ns so its edges never meet those of clk_i
	initial forever #25 clk_i = ~clk_i;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end

	// Hang guard, well above the roughly 35000 cycles the tests need
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do
			@(posedge clk_i);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	// Start a transfer and poll until the host is idle again
	task automatic run(input logic [7:0] cmd, input logic [7:0] len, input logic rd);
		apb(1'b1, CTRL_OFS, {14'h0, 1'b1, rd, len, cmd});
		do
			apb(1'b0, STAT_OFS, 32'h0);
		while (q[0] !== 1'b0);
		st = q;
	endtask

	// One quarter of a hand-made bit; high pulls the line low
	task automatic bb(input logic c, input logic d);
		@(posedge clk_i);
		lk2.host_scl_oe <= c;
		lk2.host_sda_oe <= d;
		repeat (12) @(posedge clk_i);
	endtask

	task automatic bb_byte(input logic [8:0] b);
		for (int i = 8; i >= 0; i--) begin
			bb(1'b1, !b[i]);
			bb(1'b0, !b[i]);
			ack_n = lk2.sda;
			bb(1'b0, !b[i]);
			bb(1'b1, !b[i]);
		end
	endtask

	// Byte write of 00 to offset 0, whatever the address answers
	task automatic bb_frame(input logic [7:0] a);
		logic n;
		bb(1'b0, 1'b1);
		bb(1'b1, 1'b1);
		bb_byte({a, 1'b1});
		n = ack_n;
		bb_byte({8'h80, 1'b1});
		bb_byte({8'h00, 1'b1});
		bb(1'b1, 1'b1);
		bb(1'b0, 1'b1);
		bb(1'b0, 1'b0);
		ack_n = n;
	endtask

	task end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************
	// Tests
	// ****************
	initial begin
		lk2.host_scl_o = 1'b0;
		lk2.host_sda_o = 1'b0;
		lk2.host_scl_oe = 1'b0;
		lk2.host_sda_oe = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("pins at reset", 32'h0d, 32'({test_ctl, out_en, spread_on, amt}));
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, 32'(err));
		$display("defaults done");
		run(8'h00, 8'h07, 1'b1);
		chk("block read status", 32'h80, 32'(st[7:0]));
		apb(1'b0, DATA0_OFS, 32'h0);
		chk("block read low", 32'heb007c08, q);
		apb(1'b0, DATA1_OFS, 32'h0);
		chk("block read high", 32'h130001af, q);
		$display("block read done");
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, DATA0_OFS, {24'h0, tbl[i][15:8]});
			run({3'h4, tbl[i][20:16]}, 8'h01, 1'b0);
			chk("pins after write", 32'(tbl[i][7:0]), 32'({test_ctl, out_en, spread_on, amt}));
		end
		for (int i = 0; i < 4; i++) begin
			run({3'h4, rb[i][12:8]}, 8'h01, 1'b1);
			apb(1'b0, DATA0_OFS, 32'h0);
			chk("byte read", 32'(rb[i][7:0]), 32'(q[7:0]));
		end
		$display("byte access done");
		apb(1'b1, DATA0_OFS, 32'h3c18);
		run(8'h00, 8'h02, 1'b0);
		run(8'h00, 8'h03, 1'b1);
		apb(1'b0, DATA0_OFS, 32'h0);
		chk("partial block", 32'h803c1808, q);
		$display("block write done");
		apb(1'b1, DATA0_OFS, 32'h0);
		for (int c = 1; c < 4; c++) begin
			run({1'b1, 2'(c), 5'h0}, 8'h01, 1'b0);
			chk("chip select nack", 32'h1, 32'(st[1]));
			chk("chip select pins", 32'h3, 32'(out_en));
		end
		$display("chip select done");
		bb_frame(8'ha4);
		chk("foreign ack", 32'h1, 32'(ack_n));
		chk("foreign pins", 32'h3, 32'(out_en2));
		bb_frame(8'hd2);
		chk("own ack", 32'h0, 32'(ack_n));
		chk("own pins", 32'h0, 32'(out_en2));
		$display("address done");
		end_of_test();
	end
endmodule
